//--- hdl/egha_defines.vh
// Register offsets, field positions, reset values and timing figures
// for the event gating, holdoff and arming block.
// Included by bare name from the holdoff and top design files of the block.
`ifndef EGHA_DEFINES_VH
`define EGHA_DEFINES_VH

// Per-channel register offsets; channel n adds n times the stride.
`define EGHA_CH_STRIDE 8'h20
`define EGHA_CH_CFG 8'h00
`define EGHA_CH_ARM 8'h01
`define EGHA_CH_HOLD 8'h02

// Central registers.
`define EGHA_MAIN_CTRL 8'h80
`define EGHA_MISC_CTRL 8'h81
`define EGHA_STATUS 8'h82

// Channel configuration fields.
`define EGHA_CFG_POL 0
`define EGHA_CFG_RNG_LO 1
`define EGHA_CFG_RNG_HI 3
`define EGHA_CFG_HEN 4

// Channel arming fields.
`define EGHA_ARM_SEL_LO 1
`define EGHA_ARM_SEL_HI 4
`define EGHA_ARM_EN 5

// Central main control fields.
`define EGHA_MAIN_OVERTEMP_ALARM_ENABLE 10
`define EGHA_MAIN_OT_CLR 11
`define EGHA_MAIN_SYNC_POL 12
`define EGHA_MAIN_SYNC_EN 13
`define EGHA_MAIN_POWER_DOWN 14

// Central misc control fields.
`define EGHA_MISC_RNG_LO 1
`define EGHA_MISC_RNG_HI 2
`define EGHA_MISC_QUIET 3

// Status fields.
`define EGHA_STAT_READY 0
`define EGHA_STAT_OT 1
`define EGHA_STAT_SYNC_DLL 2
`define EGHA_STAT_FAST_DLL 3

// Reset values.
`define EGHA_RST_CFG 16'h0000
`define EGHA_RST_ARM 16'h0000
`define EGHA_RST_HOLD 16'h0000
`define EGHA_RST_MAIN 16'h0000
`define EGHA_RST_MISC 16'h0000

// Quiet mode capture limit.
`define EGHA_QUIET_LIMIT 5'd16

// Timing: the holdoff step of range 1 and the core clock period, in ns.
`define EGHA_STEP_NS 10
`define EGHA_CLK_NS 40
// Range-1 steps that elapse in one core clock.
`define EGHA_STEPS_PER_CLK (`EGHA_CLK_NS / `EGHA_STEP_NS)

`endif

//--- hdl/egha_event_latch.v
// One event latch with edge select, gate and external clear.
// Assumes the event input is synchronous to the core clock.
`timescale 1ns/1ps
module egha_event_latch
(
    input wire core_clk_i,
    input wire rst_n_i,
    input wire event_i,
    input wire falling_i,
    input wire gate_i,
    input wire clear_i,
    output wire stamp_o,
    output reg latched_o
);

    reg prev;
    wire active_now;
    wire active_prev;
    wire edge_seen;

    // Fold the polarity in so one edge detector serves both edges.
    assign active_now = event_i ^ falling_i;
    assign active_prev = prev ^ falling_i;
    // A new edge needs the input back at idle first; edges while set are
    // dropped, which mirrors a latch that cannot re-fire until cleared.
    assign edge_seen = active_now & ~active_prev;
    assign stamp_o = edge_seen & gate_i & ~latched_o;

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            prev <= 1'b0;
            latched_o <= 1'b0;
        end
        else
        begin
            prev <= event_i;
            if (stamp_o)
                latched_o <= 1'b1;
            else if (clear_i)
                latched_o <= 1'b0;
        end
    end

endmodule // egha_event_latch

//--- hdl/egha_holdoff.v
// Holdoff down-counter of one event channel with range prescaler.
// Assumes a core clock whose period is a whole number of range-1 steps.
`timescale 1ns/1ps
`include "egha_defines.vh"
module egha_holdoff
#(
    parameter W = 16
)
(
    input wire core_clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire enable_i,
    input wire [2:0] range_i,
    input wire [W-1:0] load_i,
    output wire expired_o
);

    localparam integer PER_CLK_INT = `EGHA_STEPS_PER_CLK;
    localparam [W-1:0] PER_CLK = PER_CLK_INT[W-1:0];

    reg [W-1:0] count;
    reg [9:0] pre;

    // Last prescaler value before a decrement, 4**(range-2) less one.
    // Holding the value less one lets range 7 fit in ten bits.
    function [9:0] clocks_per_dec;
        input [2:0] r;
        begin
            case (r)
                3'd3: clocks_per_dec = 10'd3;
                3'd4: clocks_per_dec = 10'd15;
                3'd5: clocks_per_dec = 10'd63;
                3'd6: clocks_per_dec = 10'd255;
                3'd7: clocks_per_dec = 10'd1023;
                default: clocks_per_dec = 10'd0;
            endcase
        end
    endfunction

    wire fast;
    wire [9:0] lim;
    // Range 0 is reserved and runs as range 1.
    assign fast = (range_i == 3'd0) || (range_i == 3'd1);
    assign lim = clocks_per_dec(range_i);
    assign expired_o = (count == {W{1'b0}});

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            count <= {W{1'b0}};
            pre <= 10'd0;
        end
        else if (!enable_i)
        begin
            count <= {W{1'b0}};
            pre <= 10'd0;
        end
        else if (start_i)
        begin
            count <= load_i;
            pre <= 10'd0;
        end
        else if (!expired_o)
        begin
            // One core clock spans several 10 ns steps in range 1.
            if (fast)
                count <= (count > PER_CLK) ? count - PER_CLK
                                           : {W{1'b0}};
            else if (pre >= lim)
            begin
                pre <= 10'd0;
                count <= count - {{(W-1){1'b0}}, 1'b1};
            end
            else
                pre <= pre + 10'd1;
        end
    end

endmodule // egha_holdoff

//--- hdl/egha_gate.v
// What this block does
// - Main bit 10 enables over-temperature alarm.
// - Writing 1 to bit 11 clears alarm.
// - Main bit 12 picks sync edge.
// - Main bit 13 enables sync channel.
// - Main bit 14 powers device down.
// - Misc bits 1-2 select coarse counter range.
// - Quiet mode stops clocks, blocks event-channel stamps once sixteen are counted.
// - Status bit 0 shows unit ready.
// - Status bit 1 shows over-temperature alarm.
// - Status bit 3 shows fast clock unlocked.
// - Latch sets on programmed edge.
// - Latch held until interpolator clears it.
// - Early transitions ignored; needs idle first.
// - Preconditioning gate qualifies every event.
// - After sync, events wait for arming.
// - Each channel has 16-bit holdoff count.
// - Stamp reloads holdoff; inhibits until zero.
// - Seven ranges, step grows fourfold each.
// - Range 1 counts 10 ns steps.
// - Holdoff enable low bypasses the delay.
// - AND arming waits on selected channels.
// - OR arming needs holdoff, counter, one.
// - Config bit 0 picks channel edge.
// - Range bits share the config register.
//
// Top of the event gating, holdoff and arming block. Registers are
// reached over a simple parallel port; all inputs are core synchronous.
`timescale 1ns/1ps
`include "egha_defines.vh"
module egha_gate
#(
    parameter HOLD_W = 16
)
(
    input wire core_clk_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    input wire [3:0] event_i,
    input wire sync_i,
    input wire [3:0] interp_done_i,
    input wire sync_interp_done_i,
    input wire overtemp_detect_i,
    input wire clocks_ok_i,
    input wire coarse_ok_i,
    input wire sync_ok_i,
    input wire sync_dll_locked_i,
    input wire fast_dll_locked_i,
    output wire [3:0] stamp_o,
    output wire sync_stamp_o,
    output wire [3:0] latched_o,
    output wire sync_latched_o,
    output wire [3:0] fully_armed_o,
    output wire [1:0] coarse_range_o,
    output wire power_down_o,
    output wire overtemp_alarm_enable_o,
    output wire quiet_clock_stop_o
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg [15:0] chan_cfg [0:3];
    reg [15:0] chan_arm [0:3];
    reg [HOLD_W-1:0] chan_hold [0:3];
    reg [15:0] central_main_control;
    reg [15:0] central_misc_control;
    reg overtemp_alarm_flag;
    reg [4:0] quiet_count;
    reg [3:0] synced;
    reg sync_en_q;

    wire overtemp_alarm_enable;
    wire sync_edge_polarity;
    wire sync_channel_enable;
    wire power_down;
    wire quiet_mode;
    wire unit_ready_flag;
    wire fast_clock_lock_flag;
    wire [15:0] central_status_flags;
    wire quiet_full;
    wire [3:0] expired;
    wire [3:0] base_armed;
    wire [3:0] cross_ok;
    wire [3:0] gate;
    integer i;
    integer j;

    assign overtemp_alarm_enable = central_main_control[`EGHA_MAIN_OVERTEMP_ALARM_ENABLE];
    assign sync_edge_polarity = central_main_control[`EGHA_MAIN_SYNC_POL];
    assign sync_channel_enable = central_main_control[`EGHA_MAIN_SYNC_EN];
    assign power_down = central_main_control[`EGHA_MAIN_POWER_DOWN];
    assign quiet_mode = central_misc_control[`EGHA_MISC_QUIET];
    assign coarse_range_o =
        central_misc_control[`EGHA_MISC_RNG_HI:`EGHA_MISC_RNG_LO];
    assign power_down_o = power_down;
    assign overtemp_alarm_enable_o = overtemp_alarm_enable;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Byte address of a per-channel register.
    function [7:0] ch_addr;
        input [1:0] ch;
        input [7:0] base;
        begin
            ch_addr = base + {1'b0, ch, 5'b0_0000};
        end
    endfunction

    // Cross-channel condition from the four select bits and the three
    // other channels in order; codes above ten are reserved, never arm.
    function arm_check;
        input [3:0] code;
        input o1;
        input o2;
        input o3;
        begin
            case (code)
                4'd0: arm_check = o1;
                4'd1: arm_check = o2;
                4'd2: arm_check = o3;
                4'd3: arm_check = o1 & o2;
                4'd4: arm_check = o1 & o3;
                4'd5: arm_check = o2 & o3;
                4'd6: arm_check = o1 & o2 & o3;
                4'd7: arm_check = o1 | o2;
                4'd8: arm_check = o1 | o3;
                4'd9: arm_check = o2 | o3;
                4'd10: arm_check = o1 | o2 | o3;
                default: arm_check = 1'b0;
            endcase
        end
    endfunction

    // Number of stamps in one cycle.
    function [4:0] count4;
        input [3:0] v;
        begin
            count4 = {4'd0, v[0]} + {4'd0, v[1]} + {4'd0, v[2]}
                + {4'd0, v[3]};
        end
    endfunction

    // ****************************************************************
    // Sync channel
    // ****************************************************************
    egha_event_latch u_sync_latch
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .event_i(sync_i),
        .falling_i(sync_edge_polarity),
        .gate_i(sync_channel_enable & ~power_down),
        .clear_i(sync_interp_done_i),
        .stamp_o(sync_stamp_o),
        .latched_o(sync_latched_o)
    );

    // ****************************************************************
    // Event channels
    // ****************************************************************
    assign quiet_full = quiet_mode && quiet_count >= `EGHA_QUIET_LIMIT;
    // Busy latches mean a stamp is in flight; quiet mode parks clocks.
    assign quiet_clock_stop_o =
        quiet_mode & (|latched_o | sync_latched_o);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_chan
            // The holdoff counter doubles as the arming counter.
            assign base_armed[g] = synced[g] & expired[g];
            assign cross_ok[g] = ~chan_arm[g][`EGHA_ARM_EN]
                | arm_check(chan_arm[g][`EGHA_ARM_SEL_HI:`EGHA_ARM_SEL_LO],
                            base_armed[(g + 1) % 4],
                            base_armed[(g + 2) % 4],
                            base_armed[(g + 3) % 4]);
            assign fully_armed_o[g] = base_armed[g] & cross_ok[g];
            assign gate[g] = fully_armed_o[g] & ~power_down
                & ~quiet_full;

            egha_event_latch u_latch
            (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .event_i(event_i[g]),
                .falling_i(chan_cfg[g][`EGHA_CFG_POL]),
                .gate_i(gate[g]),
                .clear_i(interp_done_i[g]),
                .stamp_o(stamp_o[g]),
                .latched_o(latched_o[g])
            );

            egha_holdoff #(.W(HOLD_W)) u_holdoff
            (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .start_i(stamp_o[g]),
                .enable_i(chan_cfg[g][`EGHA_CFG_HEN]),
                .range_i(chan_cfg[g][`EGHA_CFG_RNG_HI:`EGHA_CFG_RNG_LO]),
                .load_i(chan_hold[g]),
                .expired_o(expired[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Sync tracking and quiet stamp count
    // ****************************************************************
    // With the sync channel off, channels are not held waiting for it.
    // Turning it on makes every channel wait for its first stamp.
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            synced <= 4'b0000;
            sync_en_q <= 1'b0;
            quiet_count <= 5'd0;
        end
        else
        begin
            sync_en_q <= sync_channel_enable;
            if (!sync_channel_enable)
                synced <= 4'b1111;
            else if (sync_stamp_o)
                synced <= 4'b1111;
            else if (!sync_en_q)
                synced <= 4'b0000;
            if (sync_stamp_o)
                quiet_count <= 5'd0;
            else if (!quiet_full)
                quiet_count <= quiet_count + count4(stamp_o);
        end
    end

    // ****************************************************************
    // Register writes and alarm
    // ****************************************************************
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                chan_cfg[i] <= `EGHA_RST_CFG;
                chan_arm[i] <= `EGHA_RST_ARM;
                chan_hold[i] <= `EGHA_RST_HOLD;
            end
            central_main_control <= `EGHA_RST_MAIN;
            central_misc_control <= `EGHA_RST_MISC;
            overtemp_alarm_flag <= 1'b0;
        end
        else
        begin
            if (reg_wr_i)
            begin
                for (i = 0; i < 4; i = i + 1)
                begin
                    if (reg_addr_i == ch_addr(i[1:0], `EGHA_CH_CFG))
                        chan_cfg[i] <= reg_wdata_i;
                    if (reg_addr_i == ch_addr(i[1:0], `EGHA_CH_ARM))
                        chan_arm[i] <= reg_wdata_i;
                    if (reg_addr_i == ch_addr(i[1:0], `EGHA_CH_HOLD))
                        chan_hold[i] <= reg_wdata_i[HOLD_W-1:0];
                end
                if (reg_addr_i == `EGHA_MAIN_CTRL)
                    central_main_control <= reg_wdata_i;
                if (reg_addr_i == `EGHA_MISC_CTRL)
                    central_misc_control <= reg_wdata_i;
            end
            // A detection in the clearing cycle keeps the alarm set.
            if (overtemp_alarm_enable & overtemp_detect_i)
                overtemp_alarm_flag <= 1'b1;
            else if (!overtemp_alarm_enable)
                overtemp_alarm_flag <= 1'b0;
            else if (reg_wr_i && reg_addr_i == `EGHA_MAIN_CTRL
                     && reg_wdata_i[`EGHA_MAIN_OT_CLR])
                overtemp_alarm_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Status and read path
    // ****************************************************************
    assign unit_ready_flag = clocks_ok_i & coarse_ok_i & sync_ok_i;
    assign fast_clock_lock_flag = ~fast_dll_locked_i;
    assign central_status_flags = {12'h000, fast_clock_lock_flag,
        ~sync_dll_locked_i, overtemp_alarm_flag, unit_ready_flag};

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
        begin
            reg_rdata_o <= 16'h0000;
            for (j = 0; j < 4; j = j + 1)
            begin
                if (reg_addr_i == ch_addr(j[1:0], `EGHA_CH_CFG))
                    reg_rdata_o <= chan_cfg[j];
                if (reg_addr_i == ch_addr(j[1:0], `EGHA_CH_ARM))
                    reg_rdata_o <= chan_arm[j];
                if (reg_addr_i == ch_addr(j[1:0], `EGHA_CH_HOLD))
                    reg_rdata_o <= {{(16-HOLD_W){1'b0}}, chan_hold[j]};
            end
            // The alarm clear bit is a strobe and always reads zero.
            if (reg_addr_i == `EGHA_MAIN_CTRL)
                reg_rdata_o <= central_main_control & 16'hF7FF;
            if (reg_addr_i == `EGHA_MISC_CTRL)
                reg_rdata_o <= central_misc_control;
            if (reg_addr_i == `EGHA_STATUS)
                reg_rdata_o <= central_status_flags;
        end
    end

endmodule // egha_gate

//--- verification/egha_gate_assertions.sv
// Port-level checks of the gating, holdoff and arming block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
module egha_gate_assertions
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [3:0] interp_done_i,
    input wire logic clocks_ok_i,
    input wire logic coarse_ok_i,
    input wire logic sync_ok_i,
    input wire logic fast_dll_locked_i,
    input wire logic [3:0] stamp_o,
    input wire logic sync_stamp_o,
    input wire logic [3:0] latched_o,
    input wire logic sync_latched_o,
    input wire logic [3:0] fully_armed_o,
    input wire logic [1:0] coarse_range_o,
    input wire logic power_down_o,
    input wire logic overtemp_alarm_enable_o,
    input wire logic quiet_clock_stop_o
);
    default clocking dc @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_main_wr;
        reg_wr_i && reg_addr_i == 8'h80;
    endsequence
    sequence s_stat_rd;
        reg_rd_i && reg_addr_i == 8'h82;
    endsequence

    pwr_down_a: assert property (s_main_wr |=>
        power_down_o == $past(reg_wdata_i[14]))
        else $error("power down bit not taken");
    ot_enable_a: assert property (s_main_wr |=>
        overtemp_alarm_enable_o == $past(reg_wdata_i[10]))
        else $error("alarm enable bit not taken");
    coarse_rng_a: assert property (reg_wr_i && reg_addr_i == 8'h81 |=>
        coarse_range_o == $past(reg_wdata_i[2:1]))
        else $error("coarse range not taken");
    ready_flag_a: assert property (s_stat_rd |=> reg_rdata_o[0] ==
        $past(clocks_ok_i && coarse_ok_i && sync_ok_i))
        else $error("ready flag wrong");
    fast_lock_a: assert property (s_stat_rd |=>
        reg_rdata_o[3] == !$past(fast_dll_locked_i))
        else $error("fast clock lock flag wrong");
    stamp_sets_a: assert property (|stamp_o |=>
        ($past(stamp_o) & ~latched_o) == 4'h0)
        else $error("stamp did not set its latch");
    latch_holds_a: assert property (|(latched_o & ~interp_done_i) |=>
        ($past(latched_o & ~interp_done_i) & ~latched_o) == 4'h0)
        else $error("latch dropped without clear");
    latch_blocks_a: assert property (
        (stamp_o & latched_o & ~interp_done_i) == 4'h0)
        else $error("stamp taken while latch busy");
    armed_gate_a: assert property ((stamp_o & ~fully_armed_o) == 4'h0)
        else $error("stamp taken while not armed");
    pd_block_a: assert property (power_down_o |->
        stamp_o == 4'h0 && !sync_stamp_o)
        else $error("stamp taken in power down");
    quiet_stop_a: assert property (
        quiet_clock_stop_o |-> (|latched_o || sync_latched_o))
        else $error("clock stop without busy latch");
endmodule // egha_gate_assertions

bind egha_gate egha_gate_assertions chk (
    .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .interp_done_i, .clocks_ok_i, .coarse_ok_i,
    .sync_ok_i, .fast_dll_locked_i, .stamp_o, .sync_stamp_o, .latched_o,
    .sync_latched_o, .fully_armed_o,
    .coarse_range_o, .power_down_o, .overtemp_alarm_enable_o,
    .quiet_clock_stop_o
);

//--- verification/egha_event_source.sv
// Event sources and interpolator model facing the gating block.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
module egha_event_source
(
    input wire logic core_clk_i,
    input wire logic [3:0] latched_i,
    input wire logic sync_latched_i,
    output logic [3:0] event_o,
    output logic sync_o,
    output logic [3:0] done_o,
    output logic sync_done_o
);
    int delay = 2;
    int cnt [5] = '{default: 0};
    logic [4:0] line = 5'h00;
    logic [4:0] done = 5'h00;
    wire [4:0] busy = {sync_latched_i, latched_i};
    assign sync_o = line[4];
    assign event_o = line[3:0];
    assign sync_done_o = done[4];
    assign done_o = done[3:0];

    // Processing time is set by delay so latches can be held long.
    always @(posedge core_clk_i)
    begin
        #1;
        for (int c = 0; c < 5; c++)
        begin
            cnt[c] = busy[c] ? cnt[c] + 1 : 0;
            done[c] = busy[c] && cnt[c] >= delay;
        end
    end

    // An edge leaves the idle level and the line returns to it after.
    task automatic pulse(input int c);
        @(posedge core_clk_i);
        #1 line[c] = ~line[c];
        repeat (2) @(posedge core_clk_i);
        #1 line[c] = ~line[c];
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask

    task automatic idle(input int c, input logic lvl);
        line[c] = lvl;
    endtask
endmodule // egha_event_source

//--- verification/egha_gate_bench.sv
// Self-checking bench for the gating, holdoff and arming block.
// Assumes the event source model and the bound port checker.
`timescale 1ns/1ps
module egha_gate_bench;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic overtemp_detect_i = 1'b0;
    logic clocks_ok_i = 1'b1;
    logic coarse_ok_i = 1'b1;
    logic sync_ok_i = 1'b1;
    logic sync_dll_locked_i = 1'b1;
    logic fast_dll_locked_i = 1'b1;
    wire [15:0] reg_rdata_o;
    wire [3:0] event_i, interp_done_i, stamp_o, latched_o, fully_armed_o;
    wire sync_i, sync_interp_done_i, sync_stamp_o, sync_latched_o;
    wire [1:0] coarse_range_o;
    wire power_down_o, overtemp_alarm_enable_o, quiet_clock_stop_o;
    int n_errors = 0;
    int comparisons = 0;
    int n_stamp [5] = '{default: 0};
    int i;
    logic [15:0] hcfg [4] = '{16'h0012, 16'h0014, 16'h0016, 16'h0002};
    logic [15:0] hcnt [4] = '{16'h0028, 16'h000A, 16'h0003, 16'h0028};
    logic [15:0] cross_map = 16'h0795;

    egha_gate #(.HOLD_W(16)) dut (
        .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .event_i, .sync_i, .interp_done_i,
        .sync_interp_done_i, .overtemp_detect_i, .clocks_ok_i, .coarse_ok_i,
        .sync_ok_i, .sync_dll_locked_i, .fast_dll_locked_i, .stamp_o,
        .sync_stamp_o, .latched_o, .sync_latched_o, .fully_armed_o,
        .coarse_range_o, .power_down_o, .overtemp_alarm_enable_o,
        .quiet_clock_stop_o
    );
    egha_event_source src (
        .core_clk_i(core_clk_i), .latched_i(latched_o),
        .sync_latched_i(sync_latched_o), .event_o(event_i), .sync_o(sync_i),
        .done_o(interp_done_i), .sync_done_o(sync_interp_done_i)
    );

    always #20 core_clk_i = ~core_clk_i;

    // Stamps are single-cycle, so they are tallied at every edge.
    always @(posedge core_clk_i)
    begin
        for (int c = 0; c < 4; c++)
            n_stamp[c] += stamp_o[c];
        n_stamp[4] += sync_stamp_o;
    end

    // ********************************
    // Access and comparison tasks
    // ********************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // A spare edge follows each strobe so no strobe is set twice at once.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(posedge core_clk_i);
        #1 reg_wr_i = 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(posedge core_clk_i);
        #1 reg_rd_i = 1'b0;
        check(reg_rdata_o, e);
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic conclude;
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end

    // ********************************
    // Test sequence
    // ********************************
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        rd(8'h80, 16'h0000);
        rd(8'h00, 16'h0000);
        wr(8'h80, 16'h7C00);
        rd(8'h80, 16'h7400);
        check({14'h0, power_down_o, overtemp_alarm_enable_o}, 16'h0003);
        wr(8'h80, 16'h0000);
        wr(8'h81, 16'h000E);
        rd(8'h81, 16'h000E);
        check({14'h0, coarse_range_o}, 16'h0003);
        wr(8'h81, 16'h0000);
        wr(8'h90, 16'hFFFF);
        rd(8'h90, 16'h0000);
        for (i = 0; i < 8; i++)
        begin
            clocks_ok_i = i[2];
            coarse_ok_i = i[1];
            sync_ok_i = i[0];
            rd(8'h82, {15'h0, i == 7});
        end
        sync_dll_locked_i = 1'b0;
        fast_dll_locked_i = 1'b0;
        rd(8'h82, 16'h000D);
        sync_dll_locked_i = 1'b1;
        fast_dll_locked_i = 1'b1;
        overtemp_detect_i = 1'b1;
        rd(8'h82, 16'h0001);
        wr(8'h80, 16'h0400);
        overtemp_detect_i = 1'b0;
        rd(8'h82, 16'h0003);
        wr(8'h80, 16'h0C00);
        rd(8'h82, 16'h0001);
        wr(8'h80, 16'h0000);
        check({12'h0, fully_armed_o}, 16'h000F);
        for (i = 0; i < 4; i++)
        begin
            wr(8'(32 * i), 16'(i % 2));
            src.idle(i, i % 2);
            src.pulse(i);
            check(16'(n_stamp[i]), 16'h0001);
        end
        src.delay = 40;
        src.pulse(0);
        src.pulse(0);
        check({15'h0, latched_o[0]}, 16'h0001);
        check(16'(n_stamp[0]), 16'h0002);
        cyc(40);
        check({15'h0, latched_o[0]}, 16'h0000);
        src.delay = 2;
        for (i = 0; i < 4; i++)
        begin
            wr(8'h40, hcfg[i]);
            wr(8'h42, hcnt[i]);
            src.pulse(2);
            cyc(1);
            check({15'h0, fully_armed_o[2]}, {15'h0, i == 3});
            cyc(11);
            check({15'h0, fully_armed_o[2]}, 16'h0001);
        end
        wr(8'h40, 16'h0014);
        wr(8'h42, 16'h00C8);
        src.pulse(2);
        for (i = 0; i < 16; i++)
        begin
            wr(8'h01, 16'h0020 | 16'(i << 1));
            check({15'h0, fully_armed_o[0]}, {15'h0, cross_map[i]});
        end
        wr(8'h01, 16'h0000);
        wr(8'h80, 16'h4000);
        src.pulse(0);
        check(16'(n_stamp[0]), 16'h0002);
        wr(8'h80, 16'h0000);
        cyc(200);
        wr(8'h81, 16'h0008);
        wr(8'h80, 16'h3000);
        src.idle(4, 1'b1);
        cyc(1);
        check({12'h0, fully_armed_o}, 16'h0000);
        src.pulse(4);
        check(16'(n_stamp[4]), 16'h0001);
        check({12'h0, fully_armed_o}, 16'h000F);
        src.delay = 40;
        src.pulse(3);
        check({15'h0, quiet_clock_stop_o}, 16'h0001);
        src.delay = 2;
        cyc(45);
        for (i = 0; i < 18; i++)
            src.pulse(3);
        check(16'(n_stamp[3]), 16'h0011);
        wr(8'h81, 16'h0000);
        wr(8'h20, 16'h001F);
        wr(8'h22, 16'h0001);
        src.pulse(1);
        cyc(1020);
        check({15'h0, fully_armed_o[1]}, 16'h0000);
        cyc(1);
        check({15'h0, fully_armed_o[1]}, 16'h0001);
        conclude();
    end
endmodule // egha_gate_bench
